// >>> shared/urm_pkg.sv
// Constants and carrier types for the UART register window and interrupt logic
package urm_pkg;
    // Register offsets (A2-A0)
    localparam logic [2:0] OFS_RXH_DLL_FLC  = 3'h0;
    localparam logic [2:0] OFS_IMSK_DLM_FCT = 3'h1;
    localparam logic [2:0] OFS_ISRC_DLD_EFN = 3'h2;
    localparam logic [2:0] OFS_LINE_CTL     = 3'h3;
    localparam logic [2:0] OFS_RES1         = 3'h4;
    localparam logic [2:0] OFS_LINE_ST      = 3'h5;
    localparam logic [2:0] OFS_PAU1         = 3'h6;
    localparam logic [2:0] OFS_PAU2         = 3'h7;
    localparam logic [2:0] OFS_RES2         = 3'h5;
    // Line control window values and field positions
    localparam logic [7:0] LCR_ENHANCED_KEY = 8'hbf;
    localparam int         LCR_DIV_BIT      = 7;
    localparam int         EFR_ENH_BIT      = 4;
    localparam int         FCR_FIFO_EN_BIT  = 0;
    localparam int         DLD_4X_BIT       = 5;
    localparam int         DLD_8X_BIT       = 4;
    // Interrupt mask bits
    localparam int         IM_RX_BIT        = 0;
    localparam int         IM_TX_BIT        = 1;
    localparam int         IM_LS_BIT        = 2;
    localparam int         IM_MS_BIT        = 3;
    // Interrupt source codes, bits 5:0
    localparam logic [5:0] ISC_LINE         = 6'h06;
    localparam logic [5:0] ISC_TIMEOUT      = 6'h0c;
    localparam logic [5:0] ISC_RX_READY     = 6'h04;
    localparam logic [5:0] ISC_TX_READY     = 6'h02;
    localparam logic [5:0] ISC_MODEM        = 6'h00;
    localparam logic [5:0] ISC_NONE         = 6'h01;
    // Reset values
    localparam logic [7:0] RST_ZERO         = 8'h00;
    localparam logic [7:0] RST_LINE_CTL     = 8'h03;
    // Time-out: four characters plus twelve bits
    localparam int         TO_CHARS         = 4;
    localparam int         TO_EXTRA_BITS    = 12;
    localparam int         OVERSAMPLE_16X   = 16;
    localparam int         OVERSAMPLE_8X    = 8;
    localparam int         OVERSAMPLE_4X    = 4;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } urm_req_s;
endpackage : urm_pkg

// >>> src/urm_regs.sv
// UART divisor, identification, enhanced window, interrupt mask and source logic
//
// Contract
// - Mask register gates rx ready, tx empty, line and modem sources into source register.
// - FIFO mode with rx mask set shows rx status in source bits 2 and 3.
// - FIFO mode raises rx-available interrupt at trigger level, drops it below.
// - Source indication and interrupt output clear together when fill falls below trigger.
// - Data ready sets on character entering FIFO, clears only when FIFO empty.
// - Divisor, fraction, revision and id at 0-2 only when divisor bit set, not 0xbf.
// - Line control 0xbf opens level count, feature, enhanced and flow chars at 4-7.
// - Mask bit 0 is zero after reset; writing one enables rx interrupt.
// - In FIFO mode, receive time-out raised when data waits four characters plus twelve bits.
`timescale 1ns/1ps
module urm_regs
    import urm_pkg::*;
#(
    parameter logic [7:0] DEV_ID    = 8'h3c, // Arbitrary value
    parameter logic [7:0] DEV_REV   = 8'h01, // Arbitrary value
    parameter int         CHAR_BITS = 10
) (
    input  wire logic     clk_i,
    input  wire logic     rst_i,
    input  wire urm_req_s host_req_i,
    output logic [7:0]    rd_data_o,
    output logic          rhr_pop_o,
    output logic          thr_push_o,
    input  wire logic [7:0] rx_data_i,
    input  wire logic     rx_push_i,
    input  wire logic [7:0] rx_level_i,
    input  wire logic [7:0] rx_trigger_i,
    input  wire logic     tx_empty_i,
    input  wire logic     line_err_i,
    input  wire logic     modem_chg_i,
    input  wire logic [7:1] line_state_i,
    output logic [15:0]   divisor_o,
    output logic          int_o
);
    localparam int TO_BITS = TO_CHARS * CHAR_BITS + TO_EXTRA_BITS;

    logic [7:0]  line_control,  next_line_control;
    logic [7:0]  interrupt_mask, next_interrupt_mask;
    logic [7:0]  fifo_control,  next_fifo_control;
    logic [7:0]  divisor_low,   next_divisor_low;
    logic [7:0]  divisor_high,  next_divisor_high;
    logic [7:0]  divisor_fraction_mode, next_divisor_fraction_mode;
    logic [7:0]  feature_control, next_feature_control;
    logic [7:0]  enhanced_function, next_enhanced_function;
    logic [7:0]  resume_char_1, next_resume_char_1;
    logic [7:0]  resume_char_2, next_resume_char_2;
    logic [7:0]  pause_char_1,  next_pause_char_1;
    logic [7:0]  pause_char_2,  next_pause_char_2;
    logic [7:0]  rd_data,       next_rd_data;
    logic        data_ready,    next_data_ready;
    logic        timeout,       next_timeout;
    logic [20:0] pre_cnt,       next_pre_cnt;
    logic [7:0]  bit_cnt,       next_bit_cnt;

    logic        enh_win, div_win, fifo_en, enh_en, rx_avail, rx_src;
    logic [3:0]  pending;
    logic [5:0]  src_code;
    logic [20:0] bit_period;
    logic        rd_rhr, wr_thr;

    // Offset compare reused by read and write paths
    function automatic logic hit(input urm_req_s r, input logic [2:0] ofs);
        return r.addr == ofs;
    endfunction : hit

    assign enh_win = line_control == LCR_ENHANCED_KEY;
    assign div_win = line_control[LCR_DIV_BIT] && !enh_win;
    assign fifo_en = fifo_control[FCR_FIFO_EN_BIT];
    assign enh_en  = enhanced_function[EFR_ENH_BIT];
    assign rd_rhr  = host_req_i.rd && !enh_win && !line_control[LCR_DIV_BIT] && hit(host_req_i, OFS_RXH_DLL_FLC);
    assign wr_thr  = host_req_i.wr && !enh_win && !line_control[LCR_DIV_BIT] && hit(host_req_i, OFS_RXH_DLL_FLC);
    assign rhr_pop_o  = rd_rhr;
    assign thr_push_o = wr_thr;
    assign divisor_o  = {divisor_high, divisor_low};

    // Non-FIFO mode falls back to data ready as the rx source
    assign rx_avail = fifo_en ? (rx_level_i >= rx_trigger_i) : data_ready;

    // Pending sources after masking
    always_comb begin
        pending[IM_RX_BIT] = interrupt_mask[IM_RX_BIT] && (rx_avail || timeout);
        pending[IM_TX_BIT] = interrupt_mask[IM_TX_BIT] && tx_empty_i;
        pending[IM_LS_BIT] = interrupt_mask[IM_LS_BIT] && line_err_i;
        pending[IM_MS_BIT] = interrupt_mask[IM_MS_BIT] && modem_chg_i;
    end

    // Priority encode; rx levels land in bits 3:2
    always_comb begin
        rx_src = interrupt_mask[IM_RX_BIT];
        if (pending[IM_LS_BIT]) begin
            src_code = ISC_LINE;
        end else if (rx_src && timeout) begin
            src_code = ISC_TIMEOUT;
        end else if (rx_src && rx_avail) begin
            src_code = ISC_RX_READY;
        end else if (pending[IM_TX_BIT]) begin
            src_code = ISC_TX_READY;
        end else if (pending[IM_MS_BIT]) begin
            src_code = ISC_MODEM;
        end else begin
            src_code = ISC_NONE;
        end
    end

    assign int_o = |pending;

    // Bit period in clocks for the time-out; zero divisor treated as one
    always_comb begin
        logic [15:0] div;
        logic [4:0]  os;
        div = (divisor_o == 16'h0000) ? 16'h0001 : divisor_o;
        os  = 5'(OVERSAMPLE_16X);
        if (enh_en && divisor_fraction_mode[DLD_4X_BIT]) begin
            os = 5'(OVERSAMPLE_4X);
        end else if (enh_en && divisor_fraction_mode[DLD_8X_BIT]) begin
            os = 5'(OVERSAMPLE_8X);
        end
        bit_period = 21'(div) * 21'(os);
    end

    // Register writes
    always_comb begin
        next_line_control         = line_control;
        next_interrupt_mask       = interrupt_mask;
        next_fifo_control         = fifo_control;
        next_divisor_low          = divisor_low;
        next_divisor_high         = divisor_high;
        next_divisor_fraction_mode = divisor_fraction_mode;
        next_feature_control      = feature_control;
        next_enhanced_function    = enhanced_function;
        next_resume_char_1        = resume_char_1;
        next_resume_char_2        = resume_char_2;
        next_pause_char_1         = pause_char_1;
        next_pause_char_2         = pause_char_2;
        if (host_req_i.wr) begin
            if (hit(host_req_i, OFS_LINE_CTL)) begin
                next_line_control = host_req_i.wdata;
            end else if (enh_win) begin
                case (host_req_i.addr)
                    OFS_IMSK_DLM_FCT: next_feature_control   = host_req_i.wdata;
                    OFS_ISRC_DLD_EFN: next_enhanced_function = host_req_i.wdata;
                    OFS_RES1:         next_resume_char_1     = host_req_i.wdata;
                    OFS_RES2:         next_resume_char_2     = host_req_i.wdata;
                    OFS_PAU1:         next_pause_char_1      = host_req_i.wdata;
                    OFS_PAU2:         next_pause_char_2      = host_req_i.wdata;
                    default: ;
                endcase
            end else if (div_win) begin
                case (host_req_i.addr)
                    OFS_RXH_DLL_FLC:  next_divisor_low  = host_req_i.wdata;
                    OFS_IMSK_DLM_FCT: next_divisor_high = host_req_i.wdata;
                    OFS_ISRC_DLD_EFN: begin
                        if (enh_en) begin
                            next_divisor_fraction_mode = host_req_i.wdata;
                        end
                    end
                    default: ;
                endcase
            end else begin
                case (host_req_i.addr)
                    OFS_IMSK_DLM_FCT: begin
                        // Upper mask bits exist only with enhanced functions on
                        next_interrupt_mask = enh_en ? host_req_i.wdata
                                                     : {4'h0, host_req_i.wdata[3:0]};
                    end
                    OFS_ISRC_DLD_EFN: next_fifo_control = host_req_i.wdata;
                    default: ;
                endcase
            end
        end
    end

    // Read mux, answered one cycle after the strobe
    always_comb begin
        next_rd_data = RST_ZERO;
        if (host_req_i.rd) begin
            if (hit(host_req_i, OFS_LINE_CTL)) begin
                next_rd_data = line_control;
            end else if (enh_win) begin
                case (host_req_i.addr)
                    OFS_RXH_DLL_FLC:  next_rd_data = rx_level_i;
                    OFS_IMSK_DLM_FCT: next_rd_data = feature_control;
                    OFS_ISRC_DLD_EFN: next_rd_data = enhanced_function;
                    OFS_RES1:         next_rd_data = resume_char_1;
                    OFS_RES2:         next_rd_data = resume_char_2;
                    OFS_PAU1:         next_rd_data = pause_char_1;
                    OFS_PAU2:         next_rd_data = pause_char_2;
                    default:          next_rd_data = RST_ZERO;
                endcase
            end else if (div_win) begin
                case (host_req_i.addr)
                    OFS_RXH_DLL_FLC:  next_rd_data = (divisor_o == 16'h0000) ? DEV_REV : divisor_low;
                    OFS_IMSK_DLM_FCT: next_rd_data = (divisor_o == 16'h0000) ? DEV_ID : divisor_high;
                    OFS_ISRC_DLD_EFN: next_rd_data = enh_en ? divisor_fraction_mode : RST_ZERO;
                    OFS_LINE_ST:      next_rd_data = {line_state_i, data_ready};
                    default:          next_rd_data = RST_ZERO;
                endcase
            end else begin
                case (host_req_i.addr)
                    OFS_RXH_DLL_FLC:  next_rd_data = rx_data_i;
                    OFS_IMSK_DLM_FCT: next_rd_data = interrupt_mask;
                    OFS_ISRC_DLD_EFN: next_rd_data = {{2{fifo_en}}, src_code};
                    OFS_LINE_ST:      next_rd_data = {line_state_i, data_ready};
                    default:          next_rd_data = RST_ZERO;
                endcase
            end
        end
    end

    // Data ready and receive time-out
    always_comb begin
        next_data_ready = data_ready;
        if (rx_level_i == 8'h00) begin
            next_data_ready = 1'b0;
        end
        if (rx_push_i) begin
            next_data_ready = 1'b1;
        end
        next_pre_cnt = pre_cnt;
        next_bit_cnt = bit_cnt;
        next_timeout = timeout;
        // Activity restarts the wait; an rx read also clears the flag
        if (rx_push_i || rd_rhr || rx_level_i == 8'h00) begin
            next_pre_cnt = '0;
            next_bit_cnt = '0;
            if (rd_rhr || rx_level_i == 8'h00) begin
                next_timeout = 1'b0;
            end
        end else if (fifo_en && !timeout) begin
            if (pre_cnt >= bit_period - 21'h000001) begin
                next_pre_cnt = '0;
                next_bit_cnt = bit_cnt + 8'h01;
                if (bit_cnt == 8'(TO_BITS - 1)) begin
                    next_timeout = 1'b1;
                end
            end else begin
                next_pre_cnt = pre_cnt + 21'h000001;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            line_control          <= RST_LINE_CTL;
            interrupt_mask        <= RST_ZERO;
            fifo_control          <= RST_ZERO;
            divisor_low           <= RST_ZERO;
            divisor_high          <= RST_ZERO;
            divisor_fraction_mode <= RST_ZERO;
            feature_control       <= RST_ZERO;
            enhanced_function     <= RST_ZERO;
            resume_char_1         <= RST_ZERO;
            resume_char_2         <= RST_ZERO;
            pause_char_1          <= RST_ZERO;
            pause_char_2          <= RST_ZERO;
            rd_data               <= RST_ZERO;
            data_ready            <= 1'b0;
            timeout               <= 1'b0;
            pre_cnt               <= '0;
            bit_cnt               <= '0;
        end else begin
            line_control          <= next_line_control;
            interrupt_mask        <= next_interrupt_mask;
            fifo_control          <= next_fifo_control;
            divisor_low           <= next_divisor_low;
            divisor_high          <= next_divisor_high;
            divisor_fraction_mode <= next_divisor_fraction_mode;
            feature_control       <= next_feature_control;
            enhanced_function     <= next_enhanced_function;
            resume_char_1         <= next_resume_char_1;
            resume_char_2         <= next_resume_char_2;
            pause_char_1          <= next_pause_char_1;
            pause_char_2          <= next_pause_char_2;
            rd_data               <= next_rd_data;
            data_ready            <= next_data_ready;
            timeout               <= next_timeout;
            pre_cnt               <= next_pre_cnt;
            bit_cnt               <= next_bit_cnt;
        end
    end

    assign rd_data_o = rd_data;

    // Checks
    a_rx_gates_int: assert property (@(posedge clk_i) disable iff (rst_i)
        (interrupt_mask[IM_RX_BIT] && rx_avail) |-> int_o)
        else $error("unmasked rx source not on interrupt");
    a_isr_rx_bits: assert property (@(posedge clk_i) disable iff (rst_i)
        (host_req_i.rd && !line_control[LCR_DIV_BIT] && hit(host_req_i, OFS_ISRC_DLD_EFN) && fifo_en
         && interrupt_mask[IM_RX_BIT] && rx_avail && !timeout && !pending[IM_LS_BIT])
        |=> rd_data_o == {2'b11, ISC_RX_READY})
        else $error("rx status not in source bits 3:2");
    a_rx_trig_level: assert property (@(posedge clk_i) disable iff (rst_i)
        fifo_en |-> (rx_avail == (rx_level_i >= rx_trigger_i)))
        else $error("rx available not tied to trigger level");
    a_clear_together: assert property (@(posedge clk_i) disable iff (rst_i)
        (fifo_en && interrupt_mask == 8'h01 && !timeout && rx_level_i < rx_trigger_i)
        |-> (!int_o && src_code == ISC_NONE))
        else $error("indication and pin did not clear together");
    a_ready_on_push: assert property (@(posedge clk_i) disable iff (rst_i)
        rx_push_i |=> data_ready)
        else $error("data ready missed a push");
    a_ready_only_empty: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(data_ready) |-> $past(rx_level_i) == 8'h00)
        else $error("data ready cleared with data left");
    a_div_window: assert property (@(posedge clk_i) disable iff (rst_i)
        (host_req_i.wr && !div_win && !hit(host_req_i, OFS_LINE_CTL)) |=> $stable(divisor_o))
        else $error("divisor written outside its window");
    a_enh_window: assert property (@(posedge clk_i) disable iff (rst_i)
        (host_req_i.wr && enh_win && hit(host_req_i, OFS_RES1)) |=> resume_char_1 == $past(host_req_i.wdata))
        else $error("flow character not written in enhanced window");
    a_mask_reset: assert property (@(posedge clk_i)
        rst_i |=> interrupt_mask[IM_RX_BIT] == 1'b0)
        else $error("rx mask not cleared by reset");
    a_timeout_set: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(timeout) |-> $past(bit_cnt) == 8'(TO_BITS - 1))
        else $error("time-out raised at wrong count");
    a_pin_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        (interrupt_mask == 8'h00) |-> !int_o)
        else $error("interrupt pin high with all masked");
    c_trig_int: cover property (@(posedge clk_i) disable iff (rst_i) fifo_en && rx_avail && int_o);
    c_timeout: cover property (@(posedge clk_i) disable iff (rst_i) $rose(timeout));
    c_enh_read: cover property (@(posedge clk_i) disable iff (rst_i) host_req_i.rd && enh_win);
endmodule : urm_regs

// >>> test/testbench.sv
// Self-checking testbench for the UART register window and interrupts
`timescale 1ns/1ps
module testbench;
    import urm_pkg::*;
    localparam logic [7:0] TB_ID  = 8'h5a; // Arbitrary value
    localparam logic [7:0] TB_REV = 8'h07; // Arbitrary value
    logic        clk_i, rst_i, rx_push_i, tx_empty_i, line_err_i, modem_chg_i;
    logic [7:0]  rx_data_i, rx_level_i, rx_trigger_i, rd_data_o, rv;
    logic [7:1]  line_state_i;
    logic        int_o, rhr_pop_o, thr_push_o;
    logic [15:0] divisor_o;
    urm_req_s    host_req;
    logic [5:0]  codes [3];
    int          miscompares, checked, n, pops, pushes;

    urm_host_model host (.clk_i(clk_i), .rd_data_i(rd_data_o), .host_req_o(host_req));

    urm_regs #(.DEV_ID(TB_ID), .DEV_REV(TB_REV)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .host_req_i(host_req), .rd_data_o(rd_data_o),
        .rhr_pop_o(rhr_pop_o), .thr_push_o(thr_push_o), .rx_data_i(rx_data_i), .rx_push_i(rx_push_i),
        .rx_level_i(rx_level_i), .rx_trigger_i(rx_trigger_i), .tx_empty_i(tx_empty_i),
        .line_err_i(line_err_i), .modem_chg_i(modem_chg_i), .line_state_i(line_state_i),
        .divisor_o(divisor_o), .int_o(int_o));

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Holding-register strobes counted at the edge that takes them
    always @(posedge clk_i) begin
        if (rhr_pop_o === 1'b1) pops++;
        if (thr_push_o === 1'b1) pushes++;
    end

    // Bounded wait for the interrupt pin
    task automatic wait_int(output int cycles);
        cycles = 0;
        while (int_o !== 1'b1 && cycles < 2000) begin
            @(negedge clk_i);
            cycles++;
        end
    endtask : wait_int

    task automatic rdchk(input logic [2:0] addr, input logic [7:0] exp);
        host.bus_read(addr, rv);
        check(16'(rv), 16'(exp));
    endtask : rdchk

    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run

    initial begin
        codes = '{ISC_TX_READY, ISC_LINE, ISC_MODEM};
        rst_i = 1'b1;
        {rx_push_i, tx_empty_i, line_err_i, modem_chg_i} = 4'h0;
        {rx_data_i, rx_level_i} = 16'h0000;
        rx_trigger_i = 8'h04;
        line_state_i = 7'h00;
        repeat (3) @(negedge clk_i);
        rst_i = 1'b0;
        begin : scenarios
        rdchk(OFS_LINE_CTL, RST_LINE_CTL);
        rdchk(OFS_IMSK_DLM_FCT, 8'h00);
        check(16'(int_o), 16'h0);
        // Divisor window: identity shows while divisor is still zero
        host.bus_write(OFS_LINE_CTL, 8'h80);
        rdchk(OFS_RXH_DLL_FLC, TB_REV);
        rdchk(OFS_IMSK_DLM_FCT, TB_ID);
        host.bus_write(OFS_RXH_DLL_FLC, 8'h05);
        host.bus_write(OFS_IMSK_DLM_FCT, 8'ha2);
        rdchk(OFS_RXH_DLL_FLC, 8'h05);
        rdchk(OFS_IMSK_DLM_FCT, 8'ha2);
        check(divisor_o, 16'ha205);
        host.bus_write(OFS_ISRC_DLD_EFN, 8'h30);
        rdchk(OFS_ISRC_DLD_EFN, 8'h00);
        // Enhanced window
        host.bus_write(OFS_LINE_CTL, LCR_ENHANCED_KEY);
        rx_level_i = 8'h1d;
        rdchk(OFS_RXH_DLL_FLC, 8'h1d);
        rx_level_i = 8'h00;
        host.bus_write(OFS_IMSK_DLM_FCT, 8'hcc);
        host.bus_write(OFS_ISRC_DLD_EFN, 8'h10);
        for (n = 4; n < 8; n++) host.bus_write(3'(n), 8'h5a ^ 8'(n));
        for (n = 4; n < 8; n++) rdchk(3'(n), 8'h5a ^ 8'(n));
        rdchk(OFS_IMSK_DLM_FCT, 8'hcc);
        rdchk(OFS_ISRC_DLD_EFN, 8'h10);
        host.bus_write(OFS_LINE_CTL, 8'h80);
        host.bus_write(OFS_ISRC_DLD_EFN, 8'h30);
        rdchk(OFS_ISRC_DLD_EFN, 8'h30);
        // Back to 16x sampling so the time-out count stays known
        host.bus_write(OFS_ISRC_DLD_EFN, 8'h00);
        host.bus_write(OFS_LINE_CTL, 8'h03);
        host.bus_write(OFS_ISRC_DLD_EFN, 8'h01);
        host.bus_write(OFS_IMSK_DLM_FCT, 8'h0f);
        for (n = 0; n < 3; n++) begin
            {tx_empty_i, line_err_i, modem_chg_i} = 3'b100 >> n;
            rdchk(OFS_ISRC_DLD_EFN, {2'b11, codes[n]});
            check(16'(int_o), 16'h1);
        end
        {tx_empty_i, line_err_i, modem_chg_i} = 3'b111;
        rdchk(OFS_ISRC_DLD_EFN, {2'b11, ISC_LINE});
        host.bus_write(OFS_IMSK_DLM_FCT, 8'h00);
        rdchk(OFS_ISRC_DLD_EFN, {2'b11, ISC_NONE});
        check(16'(int_o), 16'h0);
        {tx_empty_i, line_err_i, modem_chg_i} = 3'b000;
        // Receive trigger level, one below and at the boundary
        host.bus_write(OFS_IMSK_DLM_FCT, 8'h01);
        rx_level_i = 8'h03;
        rdchk(OFS_ISRC_DLD_EFN, {2'b11, ISC_NONE});
        rx_level_i = 8'h04;
        rdchk(OFS_ISRC_DLD_EFN, {2'b11, ISC_RX_READY});
        check(16'(int_o), 16'h1);
        rx_level_i = 8'h03;
        #1 check(16'(int_o), 16'h0);
        rdchk(OFS_ISRC_DLD_EFN, {2'b11, ISC_NONE});
        // Data ready follows pushes and an empty FIFO
        rx_level_i = 8'h00;
        line_state_i = 7'h30;
        rdchk(OFS_LINE_ST, 8'h60);
        rx_push_i = 1'b1;
        rx_level_i = 8'h01;
        @(negedge clk_i);
        rx_push_i = 1'b0;
        repeat (5) @(negedge clk_i);
        rdchk(OFS_LINE_ST, 8'h61);
        rx_level_i = 8'h00;
        rdchk(OFS_LINE_ST, 8'h60);
        // Time-out with divisor one: 4 chars of 10 bits plus 12 bits at 16x
        host.bus_write(OFS_LINE_CTL, 8'h80);
        host.bus_write(OFS_RXH_DLL_FLC, 8'h01);
        host.bus_write(OFS_IMSK_DLM_FCT, 8'h00);
        host.bus_write(OFS_LINE_CTL, 8'h03);
        rx_data_i = 8'h9e;
        rx_level_i = 8'h01;
        wait_int(n);
        if (n >= 2000) begin
            miscompares++;
            disable scenarios;
        end
        check(16'(n > 800 && n < 900), 16'h1);
        rdchk(OFS_ISRC_DLD_EFN, {2'b11, ISC_TIMEOUT});
        rdchk(OFS_RXH_DLL_FLC, 8'h9e);
        check(16'(int_o), 16'h0);
        check(divisor_o, 16'h0001);
        // Offset 0 in the normal window is the holding pair, never the divisor
        host.bus_write(OFS_RXH_DLL_FLC, 8'h3e);
        check(divisor_o, 16'h0001);
        // Non-FIFO mode: data ready is the rx source, status bits 7:6 low
        host.bus_write(OFS_ISRC_DLD_EFN, 8'h00);
        check(16'(int_o), 16'h0);
        rx_push_i = 1'b1;
        @(negedge clk_i);
        rx_push_i = 1'b0;
        check(16'(int_o), 16'h1);
        rdchk(OFS_ISRC_DLD_EFN, {2'b00, ISC_RX_READY});
        // 8x sampling halves the time-out
        host.bus_write(OFS_LINE_CTL, 8'h80);
        host.bus_write(OFS_ISRC_DLD_EFN, 8'h10);
        host.bus_write(OFS_LINE_CTL, 8'h03);
        host.bus_write(OFS_ISRC_DLD_EFN, 8'h01);
        check(16'(int_o), 16'h0);
        wait_int(n);
        if (n >= 2000) begin
            miscompares++;
            disable scenarios;
        end
        check(16'(n > 400 && n < 450), 16'h1);
        rdchk(OFS_ISRC_DLD_EFN, {2'b11, ISC_TIMEOUT});
        rdchk(OFS_RXH_DLL_FLC, 8'h9e);
        check(16'(pops), 16'h0002);
        check(16'(pushes), 16'h0001);
        end : scenarios
        complete_run();
    end
endmodule : testbench

// >>> test/urm_host_model.sv
// Host processor model driving the parallel register bus
`timescale 1ns/1ps
module urm_host_model
    import urm_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic [7:0] rd_data_i,
    output urm_req_s        host_req_o
);
    initial host_req_o = '0;

    // Strobe spans exactly one rising edge, as the block takes it
    task automatic bus_write(input logic [2:0] addr, input logic [7:0] data);
        @(negedge clk_i);
        host_req_o <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(negedge clk_i);
        host_req_o <= '0;
    endtask : bus_write

    // Read data is registered, so it is valid one cycle after the strobe
    task automatic bus_read(input logic [2:0] addr, output logic [7:0] data);
        @(negedge clk_i);
        host_req_o <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(negedge clk_i);
        host_req_o <= '0;
        data = rd_data_i;
    endtask : bus_read
endmodule : urm_host_model
